/* design/tca_core.sv */
`timescale 1ns/100ps
`default_nettype none
// Function
// - Resolutions 9 to 12 bits, steps 0.5 down to 0.0625 degrees.
// - Resolution is 12 bits after reset until reconfigured.
// - Idle after reset; conversion starts only on the start command.
// - Finished conversion writes the result register, then returns idle.
// - A 12-bit conversion completes within 750 ms.
// - External supply: read slots answer 0 while busy, 1 when done.
// - Result is 16-bit sign-extended two's complement degrees.
// - Bits 3:0 fraction, 10:4 integer, 15:11 all sign.
// - Low result bits undefined below 12 bits; here forced to zero.
// - Result register holds +85 degrees after reset.
// - Each finished conversion is compared against both alarm limits.
// - Alarm limits are signed one-byte two's complement values.
// - Limits live in storage that survives resets; resolution resets to 12 bits.
// - Upper limit at scratchpad byte 2, lower limit at byte 3.
// - Configuration byte selects which resolution is used.
// - Device carries a unique 64-bit code for selection.
// - Alarm when result at or below lower, or above upper.
// - Alarm flag re-evaluated after each conversion and cleared if gone.
// - Scratchpad bytes 0 and 1 are result low and high, read-only.
module tca_core #(
    parameter int CONV_CYC = tca_pkg::CONV_CYCLES,
    parameter logic [63:0] DEVICE_CODE = tca_pkg::DEVICE_CODE_DEF
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic i_CONV_START,
    input wire logic i_EXT_POWER,
    input wire logic [11:0] i_SENSOR_CODE,
    input wire logic i_SLOT_REQ,
    input wire logic i_SP_WR,
    input wire logic i_SP_RD,
    input wire logic [3:0] i_SP_ADDR,
    input wire logic [7:0] i_SP_WDATA,
    output logic o_BUSY,
    output logic o_SLOT_BIT,
    output logic o_SLOT_VALID,
    output logic [7:0] o_SP_RDATA,
    output logic o_SP_RVALID,
    output logic [15:0] o_TEMP,
    output logic [1:0] o_RESOLUTION,
    output logic o_ALARM,
    output logic [63:0] o_DEVICE_CODE
);
    import tca_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    tca_state_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [15:0] temp_q;
    logic [1:0] res_q;
    logic busy_q;
    logic conv_seen_q;
    logic ext_meta_q;
    logic ext_q;
    logic slot_bit_q;
    logic slot_valid_q;
    logic rd_pend_q;
    logic [3:0] rd_addr_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [63:0] code_q;
    logic nv_we;
    logic [1:0] nv_waddr;
    logic [1:0] nv_raddr0;
    logic [23:0] nv_rdata;
    logic [7:0] sp_nv_byte;
    logic [7:0] upper_lim;
    logic [7:0] lower_lim;
    logic [15:0] temp_d;
    logic [15:0] res_mask;
    logic [CNT_W-1:0] conv_len;
    logic eval;
    logic alarm;

    // ************************************************************
    // Supply-mode pin synchroniser
    // ************************************************************
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            ext_meta_q <= 1'b0;
            ext_q <= 1'b0;
        end
        else
        begin
            ext_meta_q <= i_EXT_POWER;
            ext_q <= ext_meta_q;
        end
    end

    // ************************************************************
    // Resolution dependent timing and masking
    // ************************************************************
    // Each bit less halves the time, so 9 bits takes an eighth
    assign conv_len = CNT_W'(CONV_CYC >> (2'd3 - res_q));
    assign res_mask = 16'hFFFF << (2'd3 - res_q);
    // Sign of the 12-bit code fills bits 15:12
    assign temp_d = {{4{i_SENSOR_CODE[11]}}, i_SENSOR_CODE} & res_mask;

    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            busy_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    // A start while busy is ignored by this branch
                    if (i_CONV_START)
                    begin
                        state_q <= ST_CONV;
                        // Count, store and check together fill the span
                        // exactly, so busy never overruns the limit
                        cnt_q <= conv_len - CNT_W'(3);
                        busy_q <= 1'b1;
                    end
                end
                ST_CONV:
                begin
                    if (cnt_q == '0)
                    begin
                        state_q <= ST_STORE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                ST_STORE:
                begin
                    state_q <= ST_CHECK;
                end
                ST_CHECK:
                begin
                    state_q <= ST_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Result register
    // ************************************************************
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            temp_q <= TEMP_RESET;
        end
        else if (state_q == ST_STORE)
        begin
            temp_q <= temp_d;
        end
    end

    // ************************************************************
    // Resolution setting
    // ************************************************************
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            res_q <= RES_12;
        end
        else if (i_SP_WR && i_SP_ADDR == SP_CONFIG)
        begin
            res_q <= i_SP_WDATA[CFG_RES_LSB +: 2];
        end
    end

    // ************************************************************
    // Progress answer for read slots
    // ************************************************************
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            conv_seen_q <= 1'b0;
            slot_bit_q <= 1'b1;
            slot_valid_q <= 1'b0;
        end
        else
        begin
            if (state_q == ST_IDLE && i_CONV_START)
            begin
                conv_seen_q <= 1'b1;
            end
            slot_valid_q <= i_SLOT_REQ;
            if (i_SLOT_REQ)
            begin
                // On parasite supply the line is released, reads as 1
                slot_bit_q <= !(ext_q && conv_seen_q && busy_q);
            end
        end
    end

    // ************************************************************
    // Scratchpad writes into nonvolatile store
    // ************************************************************
    always_comb
    begin
        nv_we = 1'b0;
        nv_waddr = NV_UPPER;
        unique case (i_SP_ADDR)
            SP_UPPER:
            begin
                nv_we = i_SP_WR;
                nv_waddr = NV_UPPER;
            end
            SP_LOWER:
            begin
                nv_we = i_SP_WR;
                nv_waddr = NV_LOWER;
            end
            SP_CONFIG:
            begin
                nv_we = i_SP_WR;
                nv_waddr = NV_CONFIG;
            end
            default:
            begin
                nv_we = 1'b0;
                nv_waddr = NV_UPPER;
            end
        endcase
    end

    assign nv_raddr0 = (i_SP_ADDR == SP_LOWER) ? NV_LOWER : NV_UPPER;

    tca_nv_store #(
        .W(8),
        .DEPTH(NV_DEPTH),
        .AW(2),
        .NRD(3)
    ) u_nv (
        .i_clk(I_SYS_CLK),
        .i_we(nv_we),
        .i_waddr(nv_waddr),
        .i_wdata(i_SP_WDATA),
        .i_raddr({NV_LOWER, NV_UPPER, nv_raddr0}),
        .o_rdata(nv_rdata)
    );

    assign sp_nv_byte = nv_rdata[7:0];
    assign upper_lim = nv_rdata[15:8];
    assign lower_lim = nv_rdata[23:16];

    // ************************************************************
    // Scratchpad reads, two cycles to data
    // ************************************************************
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= SP_TEMP_LO;
            rdata_q <= SP_NONE_VAL;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rd_pend_q <= i_SP_RD;
            rd_addr_q <= i_SP_ADDR;
            rvalid_q <= rd_pend_q;
            if (rd_pend_q)
            begin
                if (rd_addr_q == SP_TEMP_LO)
                begin
                    rdata_q <= temp_q[7:0];
                end
                else if (rd_addr_q == SP_TEMP_HI)
                begin
                    rdata_q <= temp_q[15:8];
                end
                else if (rd_addr_q == SP_UPPER || rd_addr_q == SP_LOWER)
                begin
                    rdata_q <= sp_nv_byte;
                end
                else if (rd_addr_q == SP_CONFIG)
                begin
                    rdata_q <= CFG_FIXED | {1'b0, res_q, 5'h00};
                end
                else if (rd_addr_q >= SP_RSVD_LO && rd_addr_q <= SP_RSVD_HI)
                begin
                    rdata_q <= SP_RSVD_VAL;
                end
                else
                begin
                    rdata_q <= SP_NONE_VAL;
                end
            end
        end
    end

    // ************************************************************
    // Alarm evaluation and identity
    // ************************************************************
    assign eval = (state_q == ST_CHECK);

    tca_alarm_cmp u_cmp (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_eval(eval),
        .i_temp(temp_q),
        .i_upper(upper_lim),
        .i_lower(lower_lim),
        .o_alarm(alarm)
    );

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            code_q <= DEVICE_CODE;
        end
        else
        begin
            code_q <= DEVICE_CODE;
        end
    end

    assign o_BUSY = busy_q;
    assign o_SLOT_BIT = slot_bit_q;
    assign o_SLOT_VALID = slot_valid_q;
    assign o_SP_RDATA = rdata_q;
    assign o_SP_RVALID = rvalid_q;
    assign o_TEMP = temp_q;
    assign o_RESOLUTION = res_q;
    assign o_ALARM = alarm;
    assign o_DEVICE_CODE = code_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_N);

    // Helper: length of the busy period in cycles
    logic [CNT_W:0] busy_len_q;
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N || !busy_q)
        begin
            busy_len_q <= '0;
        end
        else
        begin
            busy_len_q <= busy_len_q + (CNT_W+1)'(1);
        end
    end

    property p_start_only;
        $rose(busy_q) |-> $past(i_CONV_START) && $past(state_q) == ST_IDLE;
    endproperty
    a_start_only: assert property (p_start_only)
        else $error("busy rose without a start");

    property p_res_reset;
        $rose(I_RST_N) |-> res_q == RES_12 && temp_q == TEMP_RESET;
    endproperty
    a_res_reset: assert property (p_res_reset)
        else $error("wrong resolution or result after reset");

    property p_store_idle;
        state_q == ST_STORE |=> state_q == ST_CHECK ##1 (state_q == ST_IDLE
            && !busy_q && temp_q == $past(temp_q));
    endproperty
    a_store_idle: assert property (p_store_idle)
        else $error("store did not return to idle");

    property p_conv_bound;
        busy_q |-> busy_len_q < (CNT_W+1)'(CONV_CYC);
    endproperty
    a_conv_bound: assert property (p_conv_bound)
        else $error("conversion too long");

    property p_slot_busy;
        i_SLOT_REQ && ext_q && conv_seen_q && busy_q
            |=> o_SLOT_VALID && !o_SLOT_BIT;
    endproperty
    a_slot_busy: assert property (p_slot_busy)
        else $error("slot did not report busy");

    property p_slot_done;
        i_SLOT_REQ && !busy_q |=> o_SLOT_VALID && o_SLOT_BIT;
    endproperty
    a_slot_done: assert property (p_slot_done)
        else $error("slot did not report done");

    property p_sign_ext;
        temp_q[15:12] == {4{temp_q[11]}};
    endproperty
    a_sign_ext: assert property (p_sign_ext)
        else $error("result sign bits disagree");

    property p_mask9;
        state_q == ST_CHECK && res_q == RES_9 |-> temp_q[2:0] == 3'h0;
    endproperty
    a_mask9: assert property (p_mask9)
        else $error("low bits not cleared at 9 bits");

    property p_ro_temp;
        i_SP_WR && i_SP_ADDR <= SP_TEMP_HI && state_q != ST_STORE
            |=> $stable(temp_q);
    endproperty
    a_ro_temp: assert property (p_ro_temp)
        else $error("result changed by a write");

    property p_alarm;
        state_q == ST_CHECK |=> o_ALARM ==
            (($signed(temp_q[11:4]) <= $signed($past(lower_lim)))
            || ($signed(temp_q[11:4]) > $signed($past(upper_lim))));
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm flag does not match limits");

    property p_alarm_hold;
        state_q != ST_CHECK |=> $stable(o_ALARM);
    endproperty
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("alarm changed outside evaluation");
endmodule
`default_nettype wire

/* include/tca_pkg.sv */
package tca_pkg;

    // ************************************************************
    // Clock and conversion timing
    // ************************************************************
    localparam int CLK_HZ = 20000000;
    localparam int CONV_TIME_MS = 750;
    localparam int CONV_CYCLES = CONV_TIME_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 24;

    // ************************************************************
    // Resolution codes; the step shift is three minus the code
    // ************************************************************
    localparam logic [1:0] RES_9 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_11 = 2'h2;
    localparam logic [1:0] RES_12 = 2'h3;

    // ************************************************************
    // Scratchpad byte offsets
    // ************************************************************
    localparam logic [3:0] SP_TEMP_LO = 4'h0;
    localparam logic [3:0] SP_TEMP_HI = 4'h1;
    localparam logic [3:0] SP_UPPER = 4'h2;
    localparam logic [3:0] SP_LOWER = 4'h3;
    localparam logic [3:0] SP_CONFIG = 4'h4;
    localparam logic [3:0] SP_RSVD_LO = 4'h5;
    localparam logic [3:0] SP_RSVD_HI = 4'h7;
    localparam logic [7:0] SP_RSVD_VAL = 8'hFF;
    localparam logic [7:0] SP_NONE_VAL = 8'h00;

    // ************************************************************
    // Nonvolatile store layout and configuration byte
    // ************************************************************
    localparam logic [1:0] NV_UPPER = 2'h0;
    localparam logic [1:0] NV_LOWER = 2'h1;
    localparam logic [1:0] NV_CONFIG = 2'h2;
    localparam int NV_DEPTH = 3;
    localparam int CFG_RES_LSB = 5;
    localparam logic [7:0] CFG_FIXED = 8'h1F;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] TEMP_RESET = 16'h0550;

    // Arbitrary identity value, not tied to any real part
    localparam logic [63:0] DEVICE_CODE_DEF = 64'h5A3C_1E0F_7B2D_4C96;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_STORE,
        ST_CHECK
    } tca_state_e;

endpackage

/* design/tca_nv_store.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Nonvolatile byte store with several registered read ports
// ************************************************************
module tca_nv_store #(
    parameter int W = 8,
    parameter int DEPTH = 3,
    parameter int AW = 2,
    parameter int NRD = 3
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [W-1:0] i_wdata,
    input wire logic [NRD*AW-1:0] i_raddr,
    output logic [NRD*W-1:0] o_rdata
);
    // No reset: contents survive reset like the array they model
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    generate
        for (genvar p = 0; p < NRD; p++)
        begin : g_rd
            always_ff @(posedge i_clk)
            begin
                o_rdata[p*W +: W] <= mem[i_raddr[p*AW +: AW]];
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* design/tca_alarm_cmp.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Alarm comparison on the integer part of the result
// ************************************************************
module tca_alarm_cmp (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_eval,
    input wire logic [15:0] i_temp,
    input wire logic [7:0] i_upper,
    input wire logic [7:0] i_lower,
    output logic o_alarm
);
    logic signed [7:0] t_int;
    logic hit;

    // Limits are signed bytes, so compare as signed values
    assign t_int = $signed(i_temp[11:4]);
    assign hit = (t_int <= $signed(i_lower)) || (t_int > $signed(i_upper));

    // Flag follows the latest result, so it also clears
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_alarm <= 1'b0;
        end
        else if (i_eval)
        begin
            o_alarm <= hit;
        end
    end
endmodule
`default_nettype wire

/* sim/tca_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Bus master controller: commands, read slots, scratchpad
// ************************************************************
module tca_master_model (
    input wire logic i_clk,
    output logic o_conv_start,
    output logic o_slot_req,
    output logic o_sp_wr,
    output logic o_sp_rd,
    output logic [3:0] o_sp_addr,
    output logic [7:0] o_sp_wdata
);
    initial
    begin
        o_conv_start = 1'b0;
        o_slot_req = 1'b0;
        o_sp_wr = 1'b0;
        o_sp_rd = 1'b0;
        o_sp_addr = 4'hF;
        o_sp_wdata = 8'hA5;
    end

    // Start command is the only way a measurement begins
    task automatic do_start();
        @(posedge i_clk);
        o_conv_start <= 1'b1;
        @(posedge i_clk);
        o_conv_start <= 1'b0;
    endtask

    // Only used on an external supply; parasite mode never polls
    task automatic do_slot();
        @(posedge i_clk);
        o_slot_req <= 1'b1;
        @(posedge i_clk);
        o_slot_req <= 1'b0;
    endtask

    // One idle cycle after each access so a limit read sees new data
    task automatic sp_access(input logic wr, input logic [3:0] addr,
                             input logic [7:0] data);
        @(posedge i_clk);
        o_sp_wr <= wr;
        o_sp_rd <= ~wr;
        o_sp_addr <= addr;
        o_sp_wdata <= data;
        @(posedge i_clk);
        o_sp_wr <= 1'b0;
        o_sp_rd <= 1'b0;
        // Released lines never keep the last value
        o_sp_addr <= ~addr;
        o_sp_wdata <= ~data;
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

/* sim/tca_core_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tca_core_tb_top;
    import tca_pkg::*;

    // ************************************************************
    // Signals and settings
    // ************************************************************
    // Short conversion keeps the run brief; expectations scale with it
    localparam int CONV_CYC = 64;
    // Arbitrary identity value
    localparam logic [63:0] DEV_CODE = 64'h0123_4567_89AB_CDEF;
    typedef struct {
        logic [15:0] temp;
        logic alarm;
        int len;
    } tca_conv_s;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ext_power = 1'b1;
    logic [11:0] sensor_code = 12'h000;
    logic conv_start, slot_req, sp_wr, sp_rd;
    logic [3:0] sp_addr;
    logic [7:0] sp_wdata, sp_rdata;
    logic busy, slot_bit, slot_valid, sp_rvalid, alarm;
    logic [15:0] temp;
    logic [1:0] resolution;
    logic [63:0] dev_code;
    logic [7:0] upper_lim, lower_lim;
    logic [15:0] lfsr = 16'h004F;
    int miscompares = 0;
    int samples_checked = 0;
    int busy_cnt = 0;
    logic [7:0] rd_q[$];
    logic slot_q[$];
    tca_conv_s conv_q[$];

    always #25 clk = ~clk;

    tca_core #(.CONV_CYC(CONV_CYC), .DEVICE_CODE(DEV_CODE)) tca_core_inst (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .i_CONV_START(conv_start),
        .i_EXT_POWER(ext_power), .i_SENSOR_CODE(sensor_code),
        .i_SLOT_REQ(slot_req), .i_SP_WR(sp_wr), .i_SP_RD(sp_rd),
        .i_SP_ADDR(sp_addr), .i_SP_WDATA(sp_wdata), .o_BUSY(busy),
        .o_SLOT_BIT(slot_bit), .o_SLOT_VALID(slot_valid),
        .o_SP_RDATA(sp_rdata), .o_SP_RVALID(sp_rvalid), .o_TEMP(temp),
        .o_RESOLUTION(resolution), .o_ALARM(alarm),
        .o_DEVICE_CODE(dev_code)
    );

    tca_master_model tca_master_model_inst (
        .i_clk(clk), .o_conv_start(conv_start), .o_slot_req(slot_req),
        .o_sp_wr(sp_wr), .o_sp_rd(sp_rd), .o_sp_addr(sp_addr),
        .o_sp_wdata(sp_wdata)
    );

    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d",
                 samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        tca_master_model_inst.sp_access(1'b1, a, d);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        tca_master_model_inst.sp_access(1'b0, a, 8'h00);
    endtask

    task automatic slot(input logic e);
        slot_q.push_back(e);
        tca_master_model_inst.do_slot();
    endtask

    // ************************************************************
    // Output watcher: oldest note against each result
    // ************************************************************
    always @(posedge clk)
    begin
        #1;
        if (sp_rvalid === 1'b1)
            check(64'(sp_rdata), 64'(rd_q.pop_front()));
        if (slot_valid === 1'b1)
            check(64'(slot_bit), 64'(slot_q.pop_front()));
        if (busy === 1'b1)
            busy_cnt++;
        else if (busy_cnt != 0)
        begin
            check(64'(busy_cnt), 64'(conv_q[0].len));
            check(64'(temp), 64'(conv_q[0].temp));
            check(64'(alarm), 64'(conv_q[0].alarm));
            void'(conv_q.pop_front());
            busy_cnt = 0;
        end
    end

    // ************************************************************
    // Conversion scenario
    // ************************************************************
    task automatic convert(input logic [1:0] res, input logic [11:0] c);
        tca_conv_s e;
        logic [15:0] m;
        int k;
        m = 16'hFFFF << (3 - res);
        e.temp = {{4{c[11]}}, c} & m;
        e.alarm = ($signed(e.temp[11:4]) <= $signed(lower_lim)) ||
                  ($signed(e.temp[11:4]) > $signed(upper_lim));
        e.len = CONV_CYC >> (3 - res);
        @(posedge clk);
        sensor_code <= c;
        conv_q.push_back(e);
        tca_master_model_inst.do_start();
        if (ext_power)
            slot(1'b0);
        // Second start while busy must not stretch the conversion
        tca_master_model_inst.do_start();
        k = 0;
        while (busy === 1'b1 && k < 1000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        // A conversion that outlives the limit counts as a mismatch
        check(64'(busy), 64'h0);
        if (ext_power)
            slot(1'b1);
        rd(SP_TEMP_LO, e.temp[7:0]);
        rd(SP_TEMP_HI, e.temp[15:8]);
    endtask

    task automatic set_res(input logic [1:0] r);
        wr(SP_CONFIG, {1'b0, r, 5'h00});
        rd(SP_CONFIG, {1'b0, r, 5'h1F});
        check(64'(resolution), 64'(r));
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(64'(temp), 64'(TEMP_RESET));
        check(64'(resolution), 64'(RES_12));
        check(64'(busy), 64'h0);
        check(64'(slot_bit), 64'h1);
        check(dev_code, DEV_CODE);
        upper_lim = 8'h19;
        lower_lim = 8'hF6;
        wr(SP_UPPER, upper_lim);
        wr(SP_LOWER, lower_lim);
        wr(SP_TEMP_LO, 8'hAA);
        rd(SP_UPPER, upper_lim);
        rd(SP_LOWER, lower_lim);
        rd(SP_TEMP_LO, 8'h50);
        rd(SP_TEMP_HI, 8'h05);
        rd(SP_RSVD_LO, SP_RSVD_VAL);
        rd(4'h8, SP_NONE_VAL);
        // Above upper, exactly upper, at lower, just below zero
        convert(RES_12, 12'h1A0);
        convert(RES_12, 12'h191);
        convert(RES_12, 12'hF60);
        convert(RES_12, 12'hFF8);
        for (int r = 3; r >= 0; r--)
        begin
            set_res(r[1:0]);
            lfsr = lfsr_next(lfsr);
            convert(r[1:0], lfsr[11:0]);
        end
        @(posedge clk);
        ext_power <= 1'b0;
        repeat (3) @(posedge clk);
        // Parasite supply: line held high, no polling
        convert(RES_9, 12'hE70);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(64'(resolution), 64'(RES_12));
        check(64'(temp), 64'(TEMP_RESET));
        rd(SP_UPPER, upper_lim);
        rd(SP_LOWER, lower_lim);
        repeat (4) @(posedge clk);
        give_verdict();
    end

    // Whole sequence needs about 550 cycles; allow over 25 times that
    initial
    begin
        repeat (15000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
